// File: core/pesc_regs.sv
// extended ability status and extended link control registers
//
// Overview of operation
// - gigabit ability bits 14, 13, 12 of ext status always read 0.
// - ext status bits 11 to 8 always read 0000.
// - ext status bit 7 reads 1, single-pair 100 Mbit/s capable.
// - bit 6 reads 0, no reduced twisted gigabit; bits 5:0 reserved.
// - mode field accepts 0011, 1011, 1100; 0000 leaves state unchanged.
// - mode field reports 1001 in Silent, 1010 in Sleep; not commandable.
// - bit 10 enables slave jitter test; resets to 0.
// - self-clearing bit 9 restarts link training; 0 halts, default.
// - test field 000 means none, 001 to 101 select test modes 1-5.
// - test code 110 bypasses transmit scrambler and receive descrambler.
// - test code 111 is reserved and selects no function.
// - self-clearing bit 5 starts cable test; 0 stops it; resets 0.
// - bit 2 enables configuration register access; default disabled.
// - wake bit with link control off sends idle symbols as wake-up.
// - wake bit with link control on sends wake-up request symbols.
// - link control resets to the autonomous operation strap value.
// - writing an undefined mode code raises a control error event.
// - loopback path active only with basic loopback bit set.
// - disabling link control resets latched basic status indications.
`timescale 1ns/1ps
`include "pesc_params.svh"

module pesc_regs
  import pesc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // management register port
  input wire logic [`PESC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rd_valid_o,
  output logic reg_hit_o,
  // device state inputs
  input wire logic autonomous_operation_i,
  input wire logic phy_silent_i,
  input wire logic phy_sleep_i,
  input wire logic basic_loopback_i,
  // action acknowledges
  input wire logic training_ack_i,
  input wire logic cable_test_done_i,
  input wire logic wake_sent_i,
  // control outputs
  output logic link_control_o,
  output logic [3:0] mode_cmd_o,
  output logic slave_jitter_test_o,
  output logic training_restart_o,
  output logic [2:0] test_mode_o,
  output logic scrambler_bypass_o,
  output logic cable_test_o,
  output logic [1:0] loopback_mode_o,
  output logic loopback_active_o,
  output logic config_en_o,
  output logic wake_idle_o,
  output logic wake_symbol_pattern_o,
  // event outputs
  output logic control_err_o,
  output logic status_clear_o
);

  // ==========================================================
  // functions
  // ==========================================================

  // code is a mode that software may command
  function automatic logic is_mode_cmd(input logic [3:0] code);
    is_mode_cmd = (code == PESC_MODE_NORMAL) ||
                  (code == PESC_MODE_SLEEP_REQ) ||
                  (code == PESC_MODE_STANDBY);
  endfunction

  // code selects one of the compliance test patterns
  function automatic logic is_test_pat(input logic [2:0] code);
    is_test_pat = (code != `PESC_TMODE_NONE) &&
                  (code <= `PESC_TMODE_LAST);
  endfunction

  // ==========================================================
  // state
  // ==========================================================

  logic link_control;
  logic strap_taken;
  pesc_mode_t mode;
  logic jitter_en;
  logic [2:0] test_code;
  logic [1:0] loop_code;
  logic cfg_en;
  logic [2:0] sc_q;

  // ==========================================================
  // address decode
  // ==========================================================

  logic hit_status;
  logic hit_ctrl;
  logic wr_ctrl;
  logic rd_any;

  assign hit_status = (reg_addr_i == `PESC_REG_EXT_STATUS);
  assign hit_ctrl = (reg_addr_i == `PESC_REG_EXT_CTRL);
  assign wr_ctrl = reg_wr_i && hit_ctrl;
  assign rd_any = reg_rd_i && (hit_status || hit_ctrl);

  // ==========================================================
  // write field extraction
  // ==========================================================

  logic wd_link;
  logic [3:0] wd_mode;
  logic wd_jitter;
  logic wd_train;
  logic [2:0] wd_tmode;
  logic wd_cable;
  logic [1:0] wd_loop;
  logic wd_cfg;
  logic wd_wake;

  assign wd_link = reg_wdata_i[`PESC_LINK_CTRL_BIT];
  assign wd_mode = reg_wdata_i[`PESC_MODE_HI:`PESC_MODE_LO];
  assign wd_jitter = reg_wdata_i[`PESC_JITTER_BIT];
  assign wd_train = reg_wdata_i[`PESC_TRAIN_BIT];
  assign wd_tmode = reg_wdata_i[`PESC_TMODE_HI:`PESC_TMODE_LO];
  assign wd_cable = reg_wdata_i[`PESC_CABLE_BIT];
  assign wd_loop = reg_wdata_i[`PESC_LOOP_HI:`PESC_LOOP_LO];
  assign wd_cfg = reg_wdata_i[`PESC_CFG_EN_BIT];
  assign wd_wake = reg_wdata_i[`PESC_WAKE_BIT];

  // ==========================================================
  // link control and strap
  // ==========================================================

  logic next_link_control;
  logic link_falls;

  // strap value loads on the first edge after reset release
  // strap sets default
  assign next_link_control = !strap_taken ? autonomous_operation_i :
                             wr_ctrl ? wd_link : link_control;
  assign link_falls = link_control && !next_link_control;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_taken <= 1'b0;
      link_control <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
      link_control <= next_link_control;
    end
  end

  // ==========================================================
  // operating mode
  // ==========================================================

  logic mode_valid_wr;
  logic mode_bad_wr;
  pesc_mode_t next_mode;
  logic [3:0] mode_rd;

  assign mode_valid_wr = wr_ctrl && is_mode_cmd(wd_mode);
  assign mode_bad_wr = wr_ctrl && !is_mode_cmd(wd_mode) &&
                       (wd_mode != PESC_MODE_NOCHANGE);

  // 0000 and rejected codes keep the current command
  always_comb begin
    next_mode = mode;
    case (mode)
      PESC_MODE_NORMAL,
      PESC_MODE_SLEEP_REQ,
      PESC_MODE_STANDBY: begin
        if (mode_valid_wr) begin
          next_mode = pesc_mode_t'(wd_mode);
        end
      end
      default: begin
        next_mode = PESC_MODE_STANDBY;
      end
    endcase
  end

  assign mode_rd = phy_sleep_i ? PESC_MODE_SLEEP :
                   phy_silent_i ? PESC_MODE_SILENT : mode;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode <= PESC_MODE_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // plain read/write fields
  // ==========================================================

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jitter_en <= `PESC_JITTER_RST;
      test_code <= `PESC_TMODE_RST;
      loop_code <= `PESC_LOOP_RST;
      cfg_en <= `PESC_CFG_EN_RST;
    end else if (wr_ctrl) begin
      jitter_en <= wd_jitter;
      test_code <= wd_tmode;
      loop_code <= wd_loop;
      cfg_en <= wd_cfg;
    end
  end

  // ==========================================================
  // self-clearing triggers
  // ==========================================================

  logic [2:0] sc_set;
  logic [2:0] sc_clr;

  assign sc_set[PESC_SC_TRAIN] = wr_ctrl && wd_train;
  assign sc_clr[PESC_SC_TRAIN] = training_ack_i || (wr_ctrl && !wd_train);
  assign sc_set[PESC_SC_CABLE] = wr_ctrl && wd_cable;
  assign sc_clr[PESC_SC_CABLE] = cable_test_done_i ||
                                 (wr_ctrl && !wd_cable);
  assign sc_set[PESC_SC_WAKE] = wr_ctrl && wd_wake;
  assign sc_clr[PESC_SC_WAKE] = wake_sent_i;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sc
      pesc_sc_bit u_sc (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .set_i(sc_set[gi]),
        .clear_i(sc_clr[gi]),
        .bit_o(sc_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // derived controls
  // ==========================================================

  logic [2:0] next_test_sel;
  logic next_bypass;
  logic next_loop_active;
  logic next_wake_idle;
  logic next_wake_sym;

  assign next_test_sel = is_test_pat(test_code) ? test_code :
                         `PESC_TMODE_NONE;
  assign next_bypass = (test_code == `PESC_TMODE_BYPASS);
  assign next_loop_active = basic_loopback_i && !link_control;
  assign next_wake_idle = sc_q[PESC_SC_WAKE] && !link_control;
  assign next_wake_sym = sc_q[PESC_SC_WAKE] && link_control;

  // ==========================================================
  // read data
  // ==========================================================

  logic [15:0] ctrl_rd;
  logic [15:0] next_rdata;

  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`PESC_LINK_CTRL_BIT] = link_control;
    ctrl_rd[`PESC_MODE_HI:`PESC_MODE_LO] = mode_rd;
    ctrl_rd[`PESC_JITTER_BIT] = jitter_en;
    ctrl_rd[`PESC_TRAIN_BIT] = sc_q[PESC_SC_TRAIN];
    ctrl_rd[`PESC_TMODE_HI:`PESC_TMODE_LO] = test_code;
    ctrl_rd[`PESC_CABLE_BIT] = sc_q[PESC_SC_CABLE];
    ctrl_rd[`PESC_LOOP_HI:`PESC_LOOP_LO] = loop_code;
    ctrl_rd[`PESC_CFG_EN_BIT] = cfg_en;
    ctrl_rd[`PESC_WAKE_BIT] = sc_q[PESC_SC_WAKE];
  end

  always_comb begin
    if (!reg_rd_i) begin
      next_rdata = 16'h0000;
    end else if (hit_status) begin
      next_rdata = `PESC_EXT_STATUS_VAL;
    end else if (hit_ctrl) begin
      next_rdata = ctrl_rd;
    end else begin
      next_rdata = 16'h0000;
    end
  end

  // ==========================================================
  // output registers
  // ==========================================================

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rd_valid_o <= 1'b0;
      reg_hit_o <= 1'b0;
    end else begin
      reg_rdata_o <= next_rdata;
      reg_rd_valid_o <= reg_rd_i;
      reg_hit_o <= rd_any;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_control_o <= 1'b0;
      mode_cmd_o <= PESC_MODE_STANDBY;
      slave_jitter_test_o <= 1'b0;
      training_restart_o <= 1'b0;
      cable_test_o <= 1'b0;
      config_en_o <= 1'b0;
    end else begin
      link_control_o <= link_control;
      mode_cmd_o <= mode;
      slave_jitter_test_o <= jitter_en;
      training_restart_o <= sc_q[PESC_SC_TRAIN];
      cable_test_o <= sc_q[PESC_SC_CABLE];
      config_en_o <= cfg_en;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_mode_o <= `PESC_TMODE_NONE;
      scrambler_bypass_o <= 1'b0;
      loopback_mode_o <= `PESC_LOOP_RST;
      loopback_active_o <= 1'b0;
      wake_idle_o <= 1'b0;
      wake_symbol_pattern_o <= 1'b0;
    end else begin
      test_mode_o <= next_test_sel;
      scrambler_bypass_o <= next_bypass;
      loopback_mode_o <= loop_code;
      loopback_active_o <= next_loop_active;
      wake_idle_o <= next_wake_idle;
      wake_symbol_pattern_o <= next_wake_sym;
    end
  end

  // ==========================================================
  // events
  // ==========================================================

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_err_o <= 1'b0;
      status_clear_o <= 1'b0;
    end else begin
      control_err_o <= mode_bad_wr;
      status_clear_o <= link_falls && strap_taken;
    end
  end

endmodule

// File: core/pesc_params.svh
// register numbers, field positions, reset values for the ext regs
`ifndef PESC_PARAMS_SVH
`define PESC_PARAMS_SVH

// register numbers on the management port
`define PESC_ADDR_W 5
`define PESC_REG_EXT_STATUS 5'h0f
`define PESC_REG_EXT_CTRL 5'h11

// extended ability status, fixed content
`define PESC_EXT_STATUS_VAL 16'h0080
`define PESC_STS_GIGX_HD 14
`define PESC_STS_GIGT_FD 13
`define PESC_STS_GIGT_HD 12
`define PESC_STS_T1_ABLE 7
`define PESC_STS_RTG 6

// extended link control field positions
`define PESC_LINK_CTRL_BIT 15
`define PESC_MODE_HI 14
`define PESC_MODE_LO 11
`define PESC_JITTER_BIT 10
`define PESC_TRAIN_BIT 9
`define PESC_TMODE_HI 8
`define PESC_TMODE_LO 6
`define PESC_CABLE_BIT 5
`define PESC_LOOP_HI 4
`define PESC_LOOP_LO 3
`define PESC_CFG_EN_BIT 2
`define PESC_WAKE_BIT 0

// reset values
`define PESC_JITTER_RST 1'h0
`define PESC_TMODE_RST 3'h0
`define PESC_LOOP_RST 2'h0
`define PESC_CFG_EN_RST 1'h0

// test pattern codes
`define PESC_TMODE_NONE 3'h0
`define PESC_TMODE_LAST 3'h5
`define PESC_TMODE_BYPASS 3'h6

`endif

// File: core/pesc_pkg.sv
// types shared by the extended status and control register logic
package pesc_pkg;

  // operating-state codes of the mode field
  typedef enum logic [3:0] {
    PESC_MODE_NOCHANGE = 4'b0000,
    PESC_MODE_NORMAL = 4'b0011,
    PESC_MODE_SILENT = 4'b1001,
    PESC_MODE_SLEEP = 4'b1010,
    PESC_MODE_SLEEP_REQ = 4'b1011,
    PESC_MODE_STANDBY = 4'b1100
  } pesc_mode_t;

  // self-clearing trigger slots
  typedef enum logic [1:0] {
    PESC_SC_TRAIN = 2'b00,
    PESC_SC_CABLE = 2'b01,
    PESC_SC_WAKE = 2'b10
  } pesc_sc_t;

endpackage

// File: core/pesc_sc_bit.sv
// one self-clearing trigger bit
`timescale 1ns/1ps

module pesc_sc_bit (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic set_i,
  input wire logic clear_i,
  // state
  output logic bit_o
);

  logic next_bit;

  // set wins over a clear in the same cycle
  assign next_bit = set_i | (bit_o & ~clear_i);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_o <= 1'b0;
    end else begin
      bit_o <= next_bit;
    end
  end

endmodule

// File: dv/pesc_props.sv
// concurrent checks on the extended register block ports
`timescale 1ns/1ps
`include "pesc_params.svh"

module pesc_props
  import pesc_pkg::*;
(
  // clock, reset and register port
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [`PESC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_hit_o,
  // acknowledge, controls and events
  input wire logic training_ack_i,
  input wire logic link_control_o,
  input wire logic [3:0] mode_cmd_o,
  input wire logic slave_jitter_test_o,
  input wire logic training_restart_o,
  input wire logic [2:0] test_mode_o,
  input wire logic scrambler_bypass_o,
  input wire logic cable_test_o,
  input wire logic loopback_active_o,
  input wire logic wake_idle_o,
  input wire logic wake_symbol_pattern_o,
  input wire logic control_err_o,
  input wire logic status_clear_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  wire wc = reg_wr_i && reg_addr_i == `PESC_REG_EXT_CTRL;
  wire [3:0] wm = reg_wdata_i[14:11];
  wire m_ok = wm inside {4'h0, 4'h3, 4'hb, 4'hc};
  logic [15:0] wd1;
  logic [15:0] wd2;
  wire [2:0] wt = wd2[8:6];

  // write data lined up with output time
  always_ff @(posedge core_clk_i) begin
    wd1 <= reg_wdata_i;
    wd2 <= wd1;
  end

  property p_sts;
    reg_rd_i && reg_addr_i == 5'h0f |=> reg_hit_o && reg_rdata_o == 16'h0080;
  endproperty
  a_sts: assert property (p_sts) else $error("status word");
  property p_err;
    wc && !m_ok |-> ##[1:2] control_err_o;
  endproperty
  a_err: assert property (p_err) else $error("no control error");
  property p_cmd;
    wc && m_ok && wm != 4'h0 |=> ##1 mode_cmd_o == wd2[14:11];
  endproperty
  a_cmd: assert property (p_cmd) else $error("mode command");
  property p_keep;
    wc && wm == 4'h0 |=> ##1 $stable(mode_cmd_o);
  endproperty
  a_keep: assert property (p_keep) else $error("mode changed");
  property p_jit;
    wc |=> ##1 slave_jitter_test_o == wd2[10];
  endproperty
  a_jit: assert property (p_jit) else $error("jitter bit");
  property p_tst;
    wc |=> ##1 test_mode_o == (wt > 3'h5 ? 3'h0 : wt)
      && scrambler_bypass_o == (wt == 3'h6);
  endproperty
  a_tst: assert property (p_tst) else $error("test mode");
  property p_set;
    wc |=> ##1 (training_restart_o || !wd2[9]) && (cable_test_o || !wd2[5]);
  endproperty
  a_set: assert property (p_set) else $error("trigger not set");
  property p_clr;
    training_ack_i && !reg_wr_i |-> ##2 !training_restart_o;
  endproperty
  a_clr: assert property (p_clr) else $error("training stuck");
  property p_wak;
    wake_idle_o || wake_symbol_pattern_o |->
      wake_symbol_pattern_o == link_control_o && !(wake_idle_o && link_control_o);
  endproperty
  a_wak: assert property (p_wak) else $error("wake kind");
  property p_lpb;
    loopback_active_o |-> !link_control_o;
  endproperty
  a_lpb: assert property (p_lpb) else $error("loopback with link");
  property p_scl;
    $fell(link_control_o) |->
      (status_clear_o || $past(status_clear_o)) or ##1 status_clear_o;
  endproperty
  a_scl: assert property (p_scl) else $error("no status clear");
endmodule

// File: dv/pesc_smc.sv
// station management controller model driving the register port
`timescale 1ns/1ps

module pesc_smc (
  // clock
  input wire logic core_clk_i,
  // register port
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rd_valid_i,
  input wire logic reg_hit_i
);
  initial begin
    reg_addr_o = 5'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o = 1'b0;
  end

  // one-cycle strobe; released data no longer shows the word
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic [1:0] v);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    #1;
    d = reg_rdata_i;
    v = {reg_rd_valid_i, reg_hit_i};
  endtask
endmodule

// File: dv/tb.sv
// self-checking testbench for the extended register block
`timescale 1ns/1ps

module tb
  import pesc_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic aop = 1'b1, sil = 1'b0, slp = 1'b0, lpb = 1'b0;
  logic tak = 1'b0, cdn = 1'b0, wsn = 1'b0;
  logic [4:0] ra;
  logic rw, rr, rv, hit;
  logic [15:0] wd, rd, q;
  logic [1:0] qv;
  logic lc, jt, tr, sb, ct, la, ce, wi, ws, cer, scl;
  logic [3:0] mc;
  logic [2:0] tm;
  logic [1:0] lm;
  int err_total = 0;
  int comparisons = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  pesc_smc i_pesc_smc (
    .core_clk_i(core_clk_i), .reg_addr_o(ra), .reg_wr_o(rw),
    .reg_wdata_o(wd), .reg_rd_o(rr), .reg_rdata_i(rd),
    .reg_rd_valid_i(rv), .reg_hit_i(hit)
  );

  pesc_regs i_pesc_regs (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(ra),
    .reg_wr_i(rw), .reg_wdata_i(wd), .reg_rd_i(rr), .reg_rdata_o(rd),
    .reg_rd_valid_o(rv), .reg_hit_o(hit),
    .autonomous_operation_i(aop), .phy_silent_i(sil), .phy_sleep_i(slp),
    .basic_loopback_i(lpb), .training_ack_i(tak), .cable_test_done_i(cdn),
    .wake_sent_i(wsn), .link_control_o(lc), .mode_cmd_o(mc),
    .slave_jitter_test_o(jt), .training_restart_o(tr), .test_mode_o(tm),
    .scrambler_bypass_o(sb), .cable_test_o(ct), .loopback_mode_o(lm),
    .loopback_active_o(la), .config_en_o(ce), .wake_idle_o(wi),
    .wake_symbol_pattern_o(ws), .control_err_o(cer), .status_clear_o(scl)
  );

  // ====================================
  // shared tasks
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask

  // event pulse seen in either of two cycles
  task automatic win(input bit k, output logic o);
    #1;
    o = k ? scl : cer;
    settle();
    o = o | (k ? scl : cer);
  endtask

  task automatic rst(input logic v);
    @(posedge core_clk_i);
    aop <= v;
    resetn_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
  endtask

  // ====================================
  // scenarios
  task automatic t_reset();
    rst(1'b1);
    i_pesc_smc.rd(5'h11, q, qv);
    chk("ctrl strap high", q, 16'he000);
    chk("link out high", {15'h0, lc}, 16'h0001);
    rst(1'b0);
    i_pesc_smc.rd(5'h11, q, qv);
    chk("ctrl strap low", q, 16'h6000);
    chk("link out low", {15'h0, lc}, 16'h0000);
  endtask

  task automatic t_status();
    i_pesc_smc.wr(5'h0f, 16'hffff);
    i_pesc_smc.rd(5'h0f, q, qv);
    chk("status", {4'h0, qv, q[15:6]}, 16'h0c02);
    i_pesc_smc.rd(5'h05, q, qv);
    chk("unmapped", q | {14'h0, qv}, 16'h0002);
  endtask

  task automatic t_modes();
    pesc_mode_t m[3] = '{PESC_MODE_NORMAL, PESC_MODE_STANDBY,
                         PESC_MODE_SLEEP_REQ};
    logic o;
    for (int i = 0; i < 3; i++) begin
      i_pesc_smc.wr(5'h11, {1'b0, m[i], 11'h0});
      settle();
      chk("mode cmd", {12'h0, mc}, {12'h0, m[i]});
    end
    i_pesc_smc.wr(5'h11, 16'h0000);
    settle();
    chk("mode hold", {12'h0, mc}, 16'h000b);
    i_pesc_smc.wr(5'h11, 16'h2800);
    win(1'b0, o);
    chk("ctrl err", {15'h0, o}, 16'h0001);
    chk("mode kept", {12'h0, mc}, 16'h000b);
    @(posedge core_clk_i);
    sil <= 1'b1;
    i_pesc_smc.rd(5'h11, q, qv);
    chk("silent code", {12'h0, q[14:11]}, 16'h0009);
    @(posedge core_clk_i);
    slp <= 1'b1;
    i_pesc_smc.rd(5'h11, q, qv);
    chk("sleep code", {12'h0, q[14:11]}, 16'h000a);
    @(posedge core_clk_i);
    sil <= 1'b0;
    slp <= 1'b0;
  endtask

  task automatic t_fields();
    logic [15:0] d;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {5'h0, c[0], 1'b0, c, 1'b0, c[1:0], c[1], 2'b00};
      i_pesc_smc.wr(5'h11, d);
      settle();
      chk("tmode", {13'h0, tm}, {13'h0, (c > 3'h5) ? 3'h0 : c});
      chk("bypass", {15'h0, sb}, {15'h0, c == 3'h6});
      chk("fields", {12'h0, jt, lm, ce}, {12'h0, c[0], c[1:0], c[1]});
      i_pesc_smc.rd(5'h11, q, qv);
      if (c != 3'h7) begin
        chk("readback", q, d | 16'h5800);
      end
    end
  endtask

  task automatic t_sc();
    logic o;
    for (int l = 0; l < 2; l++) begin
      i_pesc_smc.wr(5'h11, {l[0], 15'h0221});
      settle();
      chk("sc set", {12'h0, tr, ct, wi, ws}, {14'h3, !l[0], l[0]});
      @(posedge core_clk_i);
      tak <= 1'b1;
      cdn <= 1'b1;
      wsn <= 1'b1;
      @(posedge core_clk_i);
      tak <= 1'b0;
      cdn <= 1'b0;
      wsn <= 1'b0;
      settle();
      chk("sc clear", {12'h0, tr, ct, wi, ws}, 16'h0000);
    end
    @(posedge core_clk_i);
    lpb <= 1'b1;
    settle();
    chk("loop link on", {15'h0, la}, 16'h0000);
    i_pesc_smc.wr(5'h11, 16'h0000);
    win(1'b1, o);
    chk("status clear", {15'h0, o}, 16'h0001);
    settle();
    chk("loop link off", {15'h0, la}, 16'h0001);
    @(posedge core_clk_i);
    lpb <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    conclude();
  end

  initial begin
    t_reset();
    t_status();
    t_modes();
    t_fields();
    t_sc();
    conclude();
  end
endmodule

bind pesc_regs pesc_props i_pesc_props (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
  .training_ack_i(training_ack_i), .link_control_o(link_control_o),
  .mode_cmd_o(mode_cmd_o), .slave_jitter_test_o(slave_jitter_test_o),
  .training_restart_o(training_restart_o), .test_mode_o(test_mode_o),
  .scrambler_bypass_o(scrambler_bypass_o), .cable_test_o(cable_test_o),
  .loopback_active_o(loopback_active_o), .wake_idle_o(wake_idle_o),
  .wake_symbol_pattern_o(wake_symbol_pattern_o),
  .control_err_o(control_err_o), .status_clear_o(status_clear_o)
);
